// ===== rmc_defs.vh
// Constants for the microcontroller core support logic
`ifndef RMC_DEFS_VH
`define RMC_DEFS_VH

// ---------------------------------------------------------------
// Register word indices (byte address divided by four)
// ---------------------------------------------------------------
`define RMC_A_INTCTL 6'h00
`define RMC_A_OPTION 6'h01
`define RMC_A_TIMER 6'h02
`define RMC_A_STATUS 6'h03
`define RMC_A_FSP 6'h04
`define RMC_A_WDOG 6'h05
`define RMC_A_PORT0 6'h06
`define RMC_A_DIR0 6'h0a
`define RMC_A_BITOP 6'h0e

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RMC_B_GIE 7
`define RMC_B_TIE 5
`define RMC_B_EIE 4
`define RMC_B_CIE 3
`define RMC_B_TIF 2
`define RMC_B_EIF 1
`define RMC_B_CIF 0
`define RMC_B_MODE 5
`define RMC_B_EDGE 4
`define RMC_B_PSA 3
`define RMC_B_IBANK 7
`define RMC_B_BANKHI 6
`define RMC_B_BANKLO 5
`define RMC_B_WDEN 0
`define RMC_B_WDCLR 1
`define RMC_B_BITVAL 5

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RMC_RST_INTCTL 8'h00
`define RMC_RST_OPTION 8'hff
`define RMC_RST_DIR 8'hff
`define RMC_RST_WDOG 8'h01
`define RMC_IRQ_VECTOR 16'h0004
`define RMC_TICK_DIV 2'h3
`define RMC_WDT_LIMIT 8'hff
`define RMC_STACK_DEPTH 8
`define RMC_INDIRECT_FILE 7'h00
`define RMC_RESP_OKAY 2'h0
`define RMC_RESP_SLVERR 2'h2

`endif

// ===== rmc_core_support.v
// Stack, data addressing, interrupts, timer, watchdog and ports of the core
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_defs.vh"

module rmc_core_support (
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, low active
  input wire [5:0] s_axi_awaddr, // Write address
  input wire [2:0] s_axi_awprot, // Write protection, unused
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [5:0] s_axi_araddr, // Read address
  input wire [2:0] s_axi_arprot, // Read protection, unused
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire call_push, // Call executes, push pc
  input wire [15:0] push_pc, // Return address for call
  input wire ret_pop, // Any return executes
  input wire irq_ack, // Core accepts interrupt
  input wire [15:0] irq_ret_pc, // Return address for interrupt
  output wire irq_request, // Interrupt pending and enabled
  output reg pc_load_r, // Load pc pulse
  output reg [15:0] pc_load_addr_r, // Value to load into pc
  input wire acc_valid, // Data access request
  input wire acc_write, // Access is a write
  input wire [6:0] acc_file, // Low instruction bits
  input wire [7:0] acc_wdata, // Write data of access
  output reg [8:0] mem_addr_r, // Data memory address
  output reg mem_we_r, // Data memory write strobe
  output reg mem_oe_r, // Data memory read strobe
  output reg [7:0] mem_wdata_r, // Data memory write data
  input wire [7:0] mem_rdata, // Data memory read data
  output reg [7:0] acc_rdata_r, // Access read result
  output reg acc_rvalid_r, // Access read result valid
  input wire ext_int_pin, // External interrupt pin
  input wire timer_external_clock_in, // External timer input pin
  input wire wdt_clk_in, // Watchdog clock pin
  input wire core_sleep, // Core is asleep
  input wire wdt_clear, // Watchdog clear instruction
  output reg wdt_reset_r, // Watchdog reset pulse
  output reg wake_r, // Wake from sleep pulse
  input wire [31:0] port_in, // Pins of ports a to d
  output reg [31:0] port_out_r, // Output latches of ports a to d
  output wire [31:0] port_oe // Driver enables, high drives
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function [7:0] pre_mask;
    input [2:0] sel;
    input shift_one;
    integer i;
    begin
      pre_mask = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        if ((i + shift_one) <= sel)
          pre_mask[i] = 1'b1;
      end
    end
  endfunction

  function is_port;
    input [5:0] idx;
    begin
      is_port = (idx >= `RMC_A_PORT0) && (idx < `RMC_A_DIR0);
    end
  endfunction

  function is_dir;
    input [5:0] idx;
    begin
      is_dir = (idx >= `RMC_A_DIR0) && (idx < `RMC_A_BITOP);
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg [34:0] sync1_r;
  reg [34:0] sync2_r;
  reg [34:0] sync3_r;
  wire [31:0] pins_s = sync2_r[31:0];
  wire int_rise = sync2_r[32] & ~sync3_r[32];
  wire tck_rise = sync2_r[33] & ~sync3_r[33];
  wire tck_fall = ~sync2_r[33] & sync3_r[33];
  wire wdt_tick = sync2_r[34] & ~sync3_r[34];

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 35'h0;
      sync2_r <= 35'h0;
      sync3_r <= 35'h0;
    end else begin
      sync1_r <= {wdt_clk_in, timer_external_clock_in, ext_int_pin, port_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  reg aw_held_r;
  reg w_held_r;
  reg [5:0] aw_idx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire [5:0] rd_idx = {2'h0, s_axi_araddr[5:2]};
  wire wr_byte = wr_fire & wstrb_r[0];
  wire wr_ok;
  reg [7:0] rd_mux;
  reg rd_ok;

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_ok = (aw_idx_r <= `RMC_A_BITOP);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 6'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RMC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RMC_RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= {2'h0, s_axi_awaddr[5:2]};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_mux};
        s_axi_rresp <= rd_ok ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  reg [7:0] intctl_r;
  reg [7:0] option_r;
  reg [7:0] timer_count_register;
  reg [7:0] status_r;
  reg [7:0] file_select_pointer;
  reg [7:0] wdog_ctl_r;
  reg [7:0] wdt_cnt_r;
  reg [31:0] direction_register;
  wire [2:0] ps_sel = option_r[2:0];
  wire prescale_on_timer = ~option_r[`RMC_B_PSA];

  // ---------------------------------------------------------------
  // Register read multiplexer
  // ---------------------------------------------------------------
  // stack not mapped
  always @* begin
    rd_mux = 8'h00;
    rd_ok = 1'b1;
    if (is_port(rd_idx)) begin
      rd_mux = pins_s[(rd_idx - `RMC_A_PORT0) * 8 +: 8];
    end else if (is_dir(rd_idx)) begin
      rd_mux = direction_register[(rd_idx - `RMC_A_DIR0) * 8 +: 8];
    end else begin
      case (rd_idx)
        `RMC_A_INTCTL: rd_mux = intctl_r;
        `RMC_A_OPTION: rd_mux = option_r;
        `RMC_A_TIMER: rd_mux = timer_count_register;
        `RMC_A_STATUS: rd_mux = status_r;
        `RMC_A_FSP: rd_mux = file_select_pointer;
        `RMC_A_WDOG: rd_mux = wdt_cnt_r;
        `RMC_A_BITOP: rd_mux = 8'h00;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Timer and prescaler
  // ---------------------------------------------------------------
  reg [1:0] div_r;
  reg [7:0] pre_cnt_r;
  wire div_tick = (div_r == `RMC_TICK_DIV);
  wire ext_edge = option_r[`RMC_B_EDGE] ? tck_fall : tck_rise;
  wire src_tick = option_r[`RMC_B_MODE] ? ext_edge : div_tick;
  wire pre_hit = ((pre_cnt_r & pre_mask(ps_sel, 1'b0)) == pre_mask(ps_sel, 1'b0));
  wire tmr_tick = src_tick & (~prescale_on_timer | pre_hit);
  wire wr_timer = wr_byte & (aw_idx_r == `RMC_A_TIMER);
  wire tmr_ovf = tmr_tick & ~wr_timer & (timer_count_register == 8'hff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 2'h0;
      pre_cnt_r <= 8'h00;
      timer_count_register <= 8'h00;
    end else begin
      div_r <= div_r + 2'h1;
      if (src_tick && prescale_on_timer)
        pre_cnt_r <= pre_cnt_r + 8'h01;
      if (wr_timer) begin
        timer_count_register <= wdata_r[7:0];
        pre_cnt_r <= 8'h00;
      end else if (tmr_tick) begin
        timer_count_register <= timer_count_register + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt controller
  // ---------------------------------------------------------------
  wire [3:0] chg_hi = sync2_r[15:12] ^ sync3_r[15:12];
  wire [2:0] irq_set = {tmr_ovf, int_rise, |chg_hi};
  wire wr_intctl = wr_byte & (aw_idx_r == `RMC_A_INTCTL);
  wire [7:0] intctl_base = wr_intctl ? wdata_r[7:0] : intctl_r;
  assign irq_request = intctl_r[`RMC_B_GIE] &
    ((intctl_r[`RMC_B_TIE] & intctl_r[`RMC_B_TIF]) |
     (intctl_r[`RMC_B_EIE] & intctl_r[`RMC_B_EIF]) |
     (intctl_r[`RMC_B_CIE] & intctl_r[`RMC_B_CIF]));

  always @(posedge aclk) begin
    if (!aresetn) begin
      intctl_r <= `RMC_RST_INTCTL;
    end else begin
      intctl_r <= intctl_base;
      intctl_r[`RMC_B_TIF] <= intctl_base[`RMC_B_TIF] | irq_set[2];
      intctl_r[`RMC_B_EIF] <= intctl_base[`RMC_B_EIF] | irq_set[1];
      intctl_r[`RMC_B_CIF] <= intctl_base[`RMC_B_CIF] | irq_set[0];
      if (irq_ack)
        intctl_r[`RMC_B_GIE] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Hardware return stack
  // ---------------------------------------------------------------
  reg [15:0] stack_mem [0:`RMC_STACK_DEPTH-1];
  reg [2:0] sp_r;
  wire do_push = irq_ack | call_push;
  wire [15:0] push_val = irq_ack ? irq_ret_pc : push_pc;

  always @(posedge aclk) begin
    if (do_push) begin
      stack_mem[sp_r] <= push_val;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sp_r <= 3'h0;
      pc_load_r <= 1'b0;
      pc_load_addr_r <= 16'h0;
    end else begin
      pc_load_r <= irq_ack | (ret_pop & ~do_push);
      if (irq_ack) begin
        pc_load_addr_r <= `RMC_IRQ_VECTOR;
      end else if (ret_pop && !do_push) begin
        pc_load_addr_r <= stack_mem[sp_r - 3'h1];
      end
      if (do_push)
        sp_r <= sp_r + 3'h1;
      else if (ret_pop)
        sp_r <= sp_r - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Data memory addressing
  // ---------------------------------------------------------------
  // window redirects
  wire use_ind = (acc_file == `RMC_INDIRECT_FILE);
  wire [8:0] ind_addr = {status_r[`RMC_B_IBANK], file_select_pointer};
  wire [8:0] dir_addr = {status_r[`RMC_B_BANKHI], status_r[`RMC_B_BANKLO], acc_file};
  wire ind_self = use_ind & (file_select_pointer[6:0] == `RMC_INDIRECT_FILE);
  reg null_rd_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr_r <= 9'h0;
      mem_we_r <= 1'b0;
      mem_oe_r <= 1'b0;
      mem_wdata_r <= 8'h00;
      null_rd_r <= 1'b0;
      acc_rdata_r <= 8'h00;
      acc_rvalid_r <= 1'b0;
    end else begin
      mem_we_r <= acc_valid & acc_write & ~ind_self;
      mem_oe_r <= acc_valid & ~acc_write & ~ind_self;
      null_rd_r <= acc_valid & ~acc_write & ind_self;
      if (acc_valid) begin
        mem_addr_r <= use_ind ? ind_addr : dir_addr;
        mem_wdata_r <= acc_wdata;
      end
      acc_rvalid_r <= mem_oe_r | null_rd_r;
      if (null_rd_r)
        acc_rdata_r <= 8'h00;
      else if (mem_oe_r)
        acc_rdata_r <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  reg [6:0] wdt_pre_r;
  reg sleep_d_r;
  wire [7:0] wmask_full = pre_mask(ps_sel, 1'b1);
  wire [6:0] wmask = wmask_full[6:0];
  wire wdt_step = wdt_tick & (prescale_on_timer | ((wdt_pre_r & wmask) == wmask));
  wire wr_wdog = wr_byte & (aw_idx_r == `RMC_A_WDOG);
  wire wdt_kick = wdt_clear | (core_sleep & ~sleep_d_r) | (wr_wdog & wdata_r[`RMC_B_WDCLR]);
  wire wdt_expire = wdog_ctl_r[`RMC_B_WDEN] & wdt_step & ~wdt_kick & (wdt_cnt_r == `RMC_WDT_LIMIT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      wdt_pre_r <= 7'h00;
      wdt_cnt_r <= 8'h00;
      sleep_d_r <= 1'b0;
      wdt_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      sleep_d_r <= core_sleep;
      if (wdt_tick)
        wdt_pre_r <= wdt_pre_r + 7'h01;
      if (wdt_kick || wdt_expire || !wdog_ctl_r[`RMC_B_WDEN]) begin
        wdt_cnt_r <= 8'h00;
        wdt_pre_r <= 7'h00;
      end else if (wdt_step) begin
        wdt_cnt_r <= wdt_cnt_r + 8'h01;
      end
      wdt_reset_r <= wdt_expire & ~core_sleep;
      wake_r <= wdt_expire & core_sleep;
    end
  end

  // ---------------------------------------------------------------
  // Plain registers and ports
  // ---------------------------------------------------------------
  wire wr_bitop = wr_byte & (aw_idx_r == `RMC_A_BITOP);
  wire [4:0] bit_idx = wdata_r[4:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      option_r <= `RMC_RST_OPTION;
      status_r <= 8'h00;
      file_select_pointer <= 8'h00;
      wdog_ctl_r <= `RMC_RST_WDOG;
    end else if (wr_byte) begin
      case (aw_idx_r)
        `RMC_A_OPTION: option_r <= wdata_r[7:0];
        `RMC_A_STATUS: status_r <= wdata_r[7:0];
        `RMC_A_FSP: file_select_pointer <= wdata_r[7:0];
        `RMC_A_WDOG: wdog_ctl_r <= {7'h00, wdata_r[`RMC_B_WDEN]};
        default: status_r <= status_r;
      endcase
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      always @(posedge aclk) begin
        if (!aresetn) begin
          port_out_r[p*8 +: 8] <= 8'h00;
          direction_register[p*8 +: 8] <= `RMC_RST_DIR;
        end else begin
          if (wr_byte && aw_idx_r == `RMC_A_PORT0 + p)
            port_out_r[p*8 +: 8] <= wdata_r[7:0];
          else if (wr_bitop && bit_idx[4:3] == p)
            port_out_r[p*8 + bit_idx[2:0]] <= wdata_r[`RMC_B_BITVAL];
          if (wr_byte && aw_idx_r == `RMC_A_DIR0 + p)
            direction_register[p*8 +: 8] <= wdata_r[7:0];
        end
      end
    end
  endgenerate

  assign port_oe = ~direction_register;

endmodule // rmc_core_support
`default_nettype wire

// ===== rmc_core_support_unused.v
// Intentionally empty; all logic lives in the principal file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== rmc_core_support_monitor.sv
// Assertion checker bound to the core support logic
`timescale 1ns/1ns
`default_nettype none
module rmc_core_support_monitor (
  input wire aclk, // Clock
  input wire aresetn, // Reset, low active
  input wire ret_pop, // Return
  input wire irq_ack, // Interrupt accept
  input wire irq_request, // Interrupt pending
  input wire pc_load_r, // Pc load
  input wire [15:0] pc_load_addr_r, // Pc value
  input wire acc_valid, // Access
  input wire acc_write, // Access write
  input wire [6:0] acc_file, // File bits
  input wire [7:0] acc_wdata, // Access data
  input wire [8:0] mem_addr_r, // Memory address
  input wire mem_we_r, // Memory write
  input wire mem_oe_r, // Memory read
  input wire [7:0] mem_wdata_r, // Memory data
  input wire [7:0] mem_rdata, // Memory read data
  input wire [7:0] acc_rdata_r, // Read result
  input wire acc_rvalid_r, // Result valid
  input wire wdt_reset_r, // Reset pulse
  input wire wake_r // Wake pulse
);
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence self_rd;
    acc_valid && !acc_write && acc_file == 7'h00 ##1 !mem_oe_r;
  endsequence
  sequence direct_wr;
    acc_valid && acc_write && acc_file != 7'h00;
  endsequence
  pop_load_a: assert property (ret_pop && !irq_ack |=> pc_load_r)
    else $error("return without pc load");
  load_cause_a: assert property (pc_load_r |-> $past(ret_pop || irq_ack))
    else $error("pc load without cause");
  ack_vector_a: assert property (irq_ack |=> pc_load_r && pc_load_addr_r == 16'h0004)
    else $error("interrupt vector wrong");
  ack_mask_a: assert property (irq_ack |=> !irq_request)
    else $error("request after accept");
  direct_wr_a: assert property (direct_wr |=> mem_we_r && mem_addr_r[6:0] == $past(acc_file)
    && mem_wdata_r == $past(acc_wdata)) else $error("direct write wrong");
  read_return_a: assert property (mem_oe_r |=> acc_rvalid_r && acc_rdata_r == $past(mem_rdata))
    else $error("read result wrong");
  self_read_a: assert property (self_rd |=> acc_rvalid_r && acc_rdata_r == 8'h00)
    else $error("window read not zero");
  self_write_a: assert property (acc_valid && acc_write && acc_file == 7'h00
    |=> !(mem_we_r && mem_addr_r[6:0] == 7'h00)) else $error("window write done");
  wake_only_a: assert property (wake_r |-> !wdt_reset_r)
    else $error("reset during wake");
endmodule // rmc_core_support_monitor

bind rmc_core_support rmc_core_support_monitor i_mon (.aclk, .aresetn, .ret_pop, .irq_ack, .irq_request,
  .pc_load_r, .pc_load_addr_r, .acc_valid, .acc_write, .acc_file, .acc_wdata, .mem_addr_r, .mem_we_r,
  .mem_oe_r, .mem_wdata_r, .mem_rdata, .acc_rdata_r, .acc_rvalid_r, .wdt_reset_r, .wake_r);
`default_nettype wire

// ===== rmc_mem_model.sv
// Data memory model on the far side of the access port
`timescale 1ns/1ns
`default_nettype none
module rmc_mem_model (
  input wire aclk, // Clock
  input wire [8:0] mem_addr_r, // Address
  input wire mem_we_r, // Write strobe
  input wire mem_oe_r, // Read strobe
  input wire [7:0] mem_wdata_r, // Write data
  output var logic [7:0] mem_rdata // Read data
);
  logic [7:0] mem [0:511];
  logic [7:0] last_r = 8'h00;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  end
  always @(posedge aclk) begin
    if (mem_we_r) mem[mem_addr_r] <= mem_wdata_r;
    if (mem_oe_r) last_r <= mem[mem_addr_r];
  end
  // Unselected lines show the inverse, never stale data
  always_comb mem_rdata = mem_oe_r ? mem[mem_addr_r] : ~last_r;
endmodule // rmc_mem_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the core support logic
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, call_push = 0, ret_pop = 0, irq_ack = 0, acc_valid = 0, acc_write = 0;
  logic ext_int_pin = 0, timer_external_clock_in = 0, wdt_clk_in = 0, core_sleep = 0, wdt_clear = 0, wdt_run = 0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, port_in = 32'h0000_003c, rd_v;
  logic [15:0] push_pc = '0, irq_ret_pc = '0;
  logic [6:0] acc_file = '0;
  logic [7:0] acc_wdata = '0;
  logic [1:0] wdt_div = '0, rs_v;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request, pc_load_r;
  wire mem_we_r, mem_oe_r, acc_rvalid_r, wdt_reset_r, wake_r;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, port_out_r, port_oe;
  wire [15:0] pc_load_addr_r;
  wire [8:0] mem_addr_r;
  wire [7:0] mem_wdata_r, mem_rdata, acc_rdata_r;
  int n_errors = 0, checked = 0, k;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} rmc_row_t;
  rmc_row_t rows [0:3];
  logic [7:0] t_opt [0:2] = '{8'h08, 8'h00, 8'h01};
  int t_div [0:2] = '{4, 8, 16};

  rmc_core_support i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .call_push, .push_pc, .ret_pop, .irq_ack, .irq_ret_pc, .irq_request, .pc_load_r,
    .pc_load_addr_r, .acc_valid, .acc_write, .acc_file, .acc_wdata, .mem_addr_r, .mem_we_r, .mem_oe_r,
    .mem_wdata_r, .mem_rdata, .acc_rdata_r, .acc_rvalid_r, .ext_int_pin, .timer_external_clock_in,
    .wdt_clk_in, .core_sleep, .wdt_clear, .wdt_reset_r, .wake_r, .port_in, .port_out_r, .port_oe);
  rmc_mem_model u_mem (.aclk, .mem_addr_r, .mem_we_r, .mem_oe_r, .mem_wdata_r, .mem_rdata);

  initial forever #10 aclk = ~aclk;
  // Watchdog clock at a quarter of the system rate
  always @(posedge aclk) begin
    wdt_div <= wdt_div + 2'h1;
    wdt_clk_in <= wdt_run & wdt_div[1];
  end
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task complete_run;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task lim(input int n, input int m);
    if (n >= m) begin
      n_errors++;
      complete_run();
    end
  endtask
  task axi_wr(input logic [5:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    lim(k, 50);
    s_axi_bready <= 1'b0;
    rs_v = s_axi_bresp;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    lim(k, 50);
    s_axi_rready <= 1'b0;
    rd_v = s_axi_rdata;
    rs_v = s_axi_rresp;
    @(posedge aclk);
  endtask
  task pop_chk(input logic [15:0] e);
    ret_pop <= 1'b1;
    @(posedge aclk);
    ret_pop <= 1'b0;
    #1;
    chk({15'h0, pc_load_r, pc_load_addr_r}, {16'h1, e});
  endtask
  task acc(input logic w, input logic [6:0] f, input logic [7:0] d);
    acc_write <= w;
    acc_file <= f;
    acc_wdata <= d;
    acc_valid <= 1'b1;
    @(posedge aclk);
    acc_valid <= 1'b0;
    for (k = 0; k < 4; k++) begin
      @(posedge aclk);
      if (acc_rvalid_r === 1'b1) break;
    end
    rd_v = (acc_rvalid_r === 1'b1) ? {24'h0, acc_rdata_r} : 32'hffff_ffff;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = '{6'h10, 8'h5a, 8'h5a};
    rows[1] = '{6'h28, 8'h0f, 8'h0f};
    rows[2] = '{6'h18, 8'ha5, 8'h3c};
    rows[3] = '{6'h34, 8'h55, 8'h55};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk({30'h0, irq_request, pc_load_r}, 32'h0);
    chk(port_oe, 32'h0);
    axi_rd(6'h04);
    chk(rd_v, 32'hff);
    axi_rd(6'h3c);
    chk({30'h0, rs_v}, 32'h2);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d);
      axi_rd(rows[i].a);
      chk(rd_v, {24'h0, rows[i].e});
    end
    chk(port_oe, 32'haa00_00f0);
    chk(port_out_r, 32'h0000_00a5);
    for (int i = 1; i <= 9; i++) begin
      push_pc <= 16'(16'h0100 + i);
      call_push <= 1'b1;
      @(posedge aclk);
    end
    call_push <= 1'b0;
    for (int i = 9; i >= 2; i--) pop_chk(16'(16'h0100 + i));
    pop_chk(16'h0109);
    axi_wr(6'h0c, 8'h40);
    acc(1'b1, 7'h25, 8'h77);
    chk({24'h0, u_mem.mem[9'h125]}, 32'h77);
    axi_wr(6'h0c, 8'h80);
    axi_wr(6'h10, 8'h33);
    acc(1'b1, 7'h00, 8'h44);
    chk({24'h0, u_mem.mem[9'h133]}, 32'h44);
    acc(1'b0, 7'h00, 8'h00);
    chk(rd_v, 32'h44);
    axi_wr(6'h10, 8'h80);
    // Preload so a real memory access would be visible
    u_mem.mem[9'h180] = 8'hee;
    acc(1'b1, 7'h00, 8'h99);
    chk({24'h0, u_mem.mem[9'h180]}, 32'hee);
    acc(1'b0, 7'h00, 8'h00);
    chk(rd_v, 32'h0);
    ext_int_pin <= 1'b1;
    port_in <= 32'h0000_f03c;
    repeat (6) @(posedge aclk);
    ext_int_pin <= 1'b0;
    axi_rd(6'h00);
    chk(rd_v, 32'h03);
    chk({31'h0, irq_request}, 32'h0);
    axi_wr(6'h00, 8'h93);
    for (k = 0; k < 8 && irq_request !== 1'b1; k++) @(posedge aclk);
    lim(k, 8);
    irq_ret_pc <= 16'h0321;
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    #1;
    chk({15'h0, pc_load_r, pc_load_addr_r}, 32'h0001_0004);
    chk({31'h0, irq_request}, 32'h0);
    axi_rd(6'h00);
    chk(rd_v, 32'h13);
    axi_wr(6'h00, 8'h10);
    axi_wr(6'h00, 8'h90);
    chk({31'h0, irq_request}, 32'h0);
    pop_chk(16'h0321);
    for (int i = 0; i < 3; i++) begin
      axi_wr(6'h04, t_opt[i]);
      axi_wr(6'h08, 8'h00);
      repeat (256) @(posedge aclk);
      axi_rd(6'h08);
      chk({31'h0, rd_v >= 32'(256 / t_div[i] - 1) && rd_v <= 32'(256 / t_div[i] + 2)}, 32'h1);
    end
    axi_wr(6'h04, 8'h08);
    axi_wr(6'h08, 8'hfe);
    repeat (20) @(posedge aclk);
    axi_rd(6'h00);
    chk(rd_v & 32'h04, 32'h04);
    // Counter mode: four rises and three falls, rising then falling edge select
    for (int m = 0; m < 2; m++) begin
      axi_wr(6'h04, m ? 8'h38 : 8'h28);
      axi_wr(6'h08, 8'h00);
      for (int j = 0; j < 7; j++) begin
        timer_external_clock_in <= ~j[0];
        repeat (4) @(posedge aclk);
      end
      axi_rd(6'h08);
      chk(rd_v, m ? 32'h3 : 32'h4);
      timer_external_clock_in <= 1'b0;
    end
    wdt_run <= 1'b1;
    for (k = 0; k < 3000 && wdt_reset_r !== 1'b1; k++) @(posedge aclk);
    lim(k, 3000);
    core_sleep <= 1'b1;
    axi_wr(6'h04, 8'h08);
    for (k = 0; k < 3000 && wake_r !== 1'b1; k++) begin
      @(posedge aclk);
      chk({31'h0, wdt_reset_r}, 32'h0);
    end
    lim(k, 3000);
    complete_run();
  end
endmodule // tb
`default_nettype wire
